// ### src/mbrfr_defs.svh
// Purpose: Constants of the read function responder.
// Assumes: Byte-wide request and response streams.
// Notes:   Offsets, codes and counts as macros.
`ifndef MBRFR_DEFS_SVH
`define MBRFR_DEFS_SVH
`define MBRFR_FC_READ_COILS    8'h01
`define MBRFR_FC_READ_INPUTS   8'h02
`define MBRFR_FC_READ_HOLDING  8'h03
`define MBRFR_FC_READ_INREGS   8'h04
`define MBRFR_FC_WRITE_COIL    8'h05
`define MBRFR_FC_ERR_BIT       8'h80
`define MBRFR_EXC_ILL_FUNC     8'h01
`define MBRFR_EXC_ILL_ADDR     8'h02
`define MBRFR_EXC_ILL_VALUE    8'h03
`define MBRFR_BCAST_ID         8'h00
`define MBRFR_MAX_ID           8'hf7
`define MBRFR_NUM_DO           16'h0008
`define MBRFR_NUM_DI           16'h0008
`define MBRFR_NUM_HOLD         16'h0008
`define MBRFR_NUM_INREG        16'h0008
`define MBRFR_HOLD_AO0         3'h0
`define MBRFR_HOLD_PRESET      3'h4
`define MBRFR_HOLD_WDOG        3'h5
`define MBRFR_HOLD_NAME        3'h6
`define MBRFR_HOLD_CONN_TMO    3'h7
`define MBRFR_IN_AI0           3'h0
`define MBRFR_IN_COUNT         3'h4
`define MBRFR_IN_NUM_DI        3'h5
`define MBRFR_IN_NUM_DO        3'h6
`define MBRFR_REQ_LEN          3'h6
`define MBRFR_COIL_ON          16'hff00
`define MBRFR_COIL_OFF         16'h0000
`endif

// ### src/mbrfr_pkg.sv
// Purpose: Types of the read function responder.
// Assumes: Nothing.
// Notes:   Constants live in the header.
package mbrfr_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RECV = 5'b00010,
    ST_HEAD = 5'b00100,
    ST_DATA = 5'b01000,
    ST_DONE = 5'b10000
  } mbrfr_state_e;
endpackage : mbrfr_pkg

// ### src/mbrfr_word_sel.sv
// Purpose: Picks the data word that a response byte needs.
// Assumes: Eight words per table, three address bits.
// Notes:   Purely combinational.
module mbrfr_word_sel (
  // Tables
  input  wire logic [127:0] HOLD_WORDS,
  input  wire logic [127:0] IN_WORDS,
  // Selection
  input  wire logic         USE_INPUT,
  input  wire logic [2:0]   INDEX,
  // Result
  output logic      [15:0]  WORD
);
  always_comb begin
    if (USE_INPUT) begin
      WORD = IN_WORDS[{INDEX, 4'h0} +: 16];
    end else begin
      WORD = HOLD_WORDS[{INDEX, 4'h0} +: 16];
    end
  end
endmodule : mbrfr_word_sel

// ### src/mbrfr_responder.sv
// Purpose: Server side interpreter of read queries and single coil writes.
// Assumes: Request bytes arrive one per valid strobe, CRC already removed.
// Notes:   Response leaves one byte per cycle while the receiver is ready.
`include "mbrfr_defs.svh"
module mbrfr_responder (
  // Clock and reset
  input  wire logic         CORE_CLK,
  input  wire logic         RESET_N,
  // Own station
  input  wire logic [7:0]   STATION_NUMBER,
  // Request byte stream
  input  wire logic         RX_VALID,
  input  wire logic [7:0]   RX_DATA,
  input  wire logic         RX_END,
  // Response byte stream
  output logic              TX_VALID,
  output logic      [7:0]   TX_DATA,
  output logic              TX_LAST,
  input  wire logic         TX_READY,
  // Field values
  input  wire logic [7:0]   BINARY_INPUT_CHANNEL,
  input  wire logic [63:0]  ANALOG_INPUT_VALUE,
  input  wire logic [15:0]  COUNTER_VALUE,
  input  wire logic [63:0]  ANALOG_OUTPUT_VALUE,
  input  wire logic [15:0]  COUNTER_PRESET,
  input  wire logic [15:0]  WATCHDOG_TIMEOUT,
  input  wire logic [15:0]  MODULE_NAME,
  input  wire logic [15:0]  CONN_TIMEOUT,
  // Coil outputs
  output logic      [7:0]   COILS,
  output logic              COIL_WRITE
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    mbrfr_pkg::mbrfr_state_e st;
    logic [47:0] req;
    logic [2:0]  nrx;
    logic        sync;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0]  func;
    logic [7:0]  exc;
    logic [7:0]  nbytes;
    logic [7:0]  idx;
    logic [1:0]  head;
    logic [7:0]  coils;
    logic        wr;
    logic [7:0]  di_meta;
    logic [7:0]  di_sync;
  } mbrfr_s;
  mbrfr_s r_q;
  mbrfr_s r_d;
  logic [15:0]  word;
  logic [127:0] hold_words;
  logic [127:0] in_words;
  logic [7:0]   bits;
  logic [15:0]  lim;
  logic [15:0]  last;
  // Holding and input register images.
  assign hold_words = {CONN_TIMEOUT, MODULE_NAME, WATCHDOG_TIMEOUT,
                       COUNTER_PRESET, ANALOG_OUTPUT_VALUE};
  assign in_words = {16'h0000, `MBRFR_NUM_DO, `MBRFR_NUM_DI,
                     COUNTER_VALUE, ANALOG_INPUT_VALUE};
  mbrfr_word_sel u_sel (
    .HOLD_WORDS (hold_words),
    .IN_WORDS   (in_words),
    .USE_INPUT  (r_q.func == `MBRFR_FC_READ_INREGS),
    .INDEX      (r_q.start[2:0] + r_q.idx[3:1]),
    .WORD       (word)
  );
  // Packs eight points starting at a given bit position.
  function automatic logic [7:0] pack8(input logic [7:0] src,
                                       input logic [15:0] first,
                                       input logic [15:0] cnt,
                                       input logic [7:0] byte_no);
    logic [15:0] p;
    pack8 = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p = 16'({byte_no, 3'h0}) + 16'(i);
      if (p < cnt) begin
        pack8[i] = src[3'(first + p)];
      end
    end
  endfunction : pack8
  always_comb begin
    if (r_q.func == `MBRFR_FC_READ_COILS) begin
      bits = pack8(r_q.coils, r_q.start, r_q.count, r_q.idx);
    end else begin
      bits = pack8(r_q.di_sync, r_q.start, r_q.count,
                   r_q.idx);
    end
  end
  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    r_d = r_q;
    r_d.wr = 1'b0;
    // Two flip-flops bring the input pins into the clock domain.
    r_d.di_meta = BINARY_INPUT_CHANNEL;
    r_d.di_sync = r_q.di_meta;
    TX_VALID = 1'b0;
    TX_DATA = 8'h00;
    TX_LAST = 1'b0;
    lim = 16'h0000;
    last = 16'h0000;
    case (r_q.st)
      mbrfr_pkg::ST_IDLE, mbrfr_pkg::ST_RECV: begin
        if (RX_VALID) begin
          r_d.st = mbrfr_pkg::ST_RECV;
          if (r_q.nrx < `MBRFR_REQ_LEN) begin
            r_d.req = {r_q.req[39:0], RX_DATA};
            r_d.nrx = r_q.nrx + 3'h1;
          end else begin
            r_d.sync = 1'b0;
          end
        end
        if (RX_END) begin
          r_d.nrx = 3'h0;
          r_d.st = mbrfr_pkg::ST_HEAD;
          r_d.func = r_q.req[39:32];
          r_d.start = r_q.req[31:16];
          r_d.count = r_q.req[15:0];
          r_d.exc = 8'h00;
          r_d.head = 2'h0;
          r_d.idx = 8'h00;
          if (r_q.nrx != `MBRFR_REQ_LEN || !r_q.sync ||
              (r_q.req[47:40] != STATION_NUMBER &&
               r_q.req[47:40] != `MBRFR_BCAST_ID)) begin
            r_d.st = mbrfr_pkg::ST_IDLE;
          end
          r_d.sync = 1'b1;
          case (r_q.req[39:32])
            `MBRFR_FC_READ_COILS: lim = `MBRFR_NUM_DO;
            `MBRFR_FC_READ_INPUTS: lim = `MBRFR_NUM_DI;
            `MBRFR_FC_READ_HOLDING: lim = `MBRFR_NUM_HOLD;
            `MBRFR_FC_READ_INREGS: lim = `MBRFR_NUM_INREG;
            `MBRFR_FC_WRITE_COIL: lim = `MBRFR_NUM_DO;
            default: r_d.exc = `MBRFR_EXC_ILL_FUNC;
          endcase
          last = r_q.req[31:16] + r_q.req[15:0];
          if (r_d.exc == 8'h00) begin
            if (r_q.req[39:32] == `MBRFR_FC_WRITE_COIL) begin
              if (r_q.req[31:16] >= lim) begin
                r_d.exc = `MBRFR_EXC_ILL_ADDR;
              end else if (r_q.req[15:0] != `MBRFR_COIL_ON &&
                           r_q.req[15:0] != `MBRFR_COIL_OFF) begin
                r_d.exc = `MBRFR_EXC_ILL_VALUE;
              end else begin
                r_d.coils[r_q.req[18:16]] = r_q.req[15];
                r_d.wr = 1'b1;
              end
            end else if (r_q.req[15:0] == 16'h0000 ||
                         r_q.req[15:0] > lim) begin
              r_d.exc = `MBRFR_EXC_ILL_VALUE;
            end else if (last > lim || last < r_q.req[31:16]) begin
              r_d.exc = `MBRFR_EXC_ILL_ADDR;
            end
          end
          if (r_q.req[39:32] <= `MBRFR_FC_READ_INPUTS) begin
            r_d.nbytes = 8'((r_q.req[15:0] + 16'h0007) >> 3);
          end else begin
            r_d.nbytes = 8'({r_q.req[14:0], 1'b0});
          end
          if (r_q.req[47:40] == `MBRFR_BCAST_ID) begin
            r_d.st = mbrfr_pkg::ST_IDLE;
          end
        end
      end
      mbrfr_pkg::ST_HEAD: begin
        TX_VALID = 1'b1;
        case (r_q.head)
          2'h0: TX_DATA = STATION_NUMBER;
          2'h1: begin
            if (r_q.exc != 8'h00) begin
              TX_DATA = r_q.func | `MBRFR_FC_ERR_BIT;
            end else begin
              TX_DATA = r_q.func;
            end
          end
          default: begin
            if (r_q.exc != 8'h00) begin
              TX_DATA = r_q.exc;
              TX_LAST = 1'b1;
            end else if (r_q.func == `MBRFR_FC_WRITE_COIL) begin
              TX_DATA = r_q.start[15:8];
            end else begin
              TX_DATA = r_q.nbytes;
            end
          end
        endcase
        if (TX_READY) begin
          r_d.head = r_q.head + 2'h1;
          if (r_q.head == 2'h2) begin
            if (r_q.exc != 8'h00) begin
              r_d.st = mbrfr_pkg::ST_IDLE;
            end else begin
              r_d.st = mbrfr_pkg::ST_DATA;
            end
          end
        end
      end
      mbrfr_pkg::ST_DATA: begin
        TX_VALID = 1'b1;
        if (r_q.func == `MBRFR_FC_WRITE_COIL) begin
          case (r_q.idx[1:0])
            2'h0: TX_DATA = r_q.start[7:0];
            2'h1: TX_DATA = r_q.count[15:8];
            default: TX_DATA = r_q.count[7:0];
          endcase
          TX_LAST = (r_q.idx == 8'h02);
        end else begin
          if (r_q.func <= `MBRFR_FC_READ_INPUTS) begin
            TX_DATA = bits;
          end else if (!r_q.idx[0]) begin
            TX_DATA = word[15:8];
          end else begin
            TX_DATA = word[7:0];
          end
          TX_LAST = (r_q.idx == r_q.nbytes - 8'h01);
        end
        if (TX_READY) begin
          r_d.idx = r_q.idx + 8'h01;
          if (TX_LAST) begin
            r_d.st = mbrfr_pkg::ST_IDLE;
          end
        end
      end
      default: r_d.st = mbrfr_pkg::ST_IDLE;
    endcase
  end
  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_q <= '{st: mbrfr_pkg::ST_IDLE, sync: 1'b1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end
  assign COILS = r_q.coils;
  assign COIL_WRITE = r_q.wr;
endmodule : mbrfr_responder

// ### verification/mbrfr_monitor.sv
// Purpose: Concurrent checks on the responder's ports.
// Assumes: One clock domain, asynchronous active low reset.
// Notes:   Attached to every responder by bind.
// ********************************************************************
// Checker
// ********************************************************************
module mbrfr_monitor (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET_N,
  // Request and response streams
  input  wire logic       RX_END,
  input  wire logic [7:0] STATION_NUMBER,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_LAST,
  input  wire logic       TX_READY,
  // Coils
  input  wire logic [7:0] COILS,
  input  wire logic       COIL_WRITE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] idx_q;
  logic [7:0] fc_q;
  logic [7:0] cnt_q;
  // Count accepted bytes and keep the code and count bytes.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      idx_q <= 8'h00;
      fc_q  <= 8'h00;
      cnt_q <= 8'h00;
    end else if (TX_VALID && TX_READY) begin
      idx_q <= TX_LAST ? 8'h00 : idx_q + 8'h01;
      if (idx_q == 8'h01) fc_q <= TX_DATA;
      if (idx_q == 8'h02) cnt_q <= TX_DATA;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  hold_byte_a: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("Response byte changed before acceptance.");
  first_station_a: assert property ($rose(TX_VALID) |->
    $past(RX_END) && TX_DATA == STATION_NUMBER)
    else $error("Response did not open with the station.");
  exc_short_a: assert property (
    TX_VALID && idx_q == 8'h02 && fc_q[7] |-> TX_LAST)
    else $error("Exception response longer than three bytes.");
  bit_count_a: assert property (TX_VALID && idx_q == 8'h02 &&
    fc_q inside {8'h01, 8'h02} |-> TX_DATA == 8'h01)
    else $error("Bad byte count for a bit read.");
  reg_count_a: assert property (TX_VALID && idx_q == 8'h02 &&
    fc_q inside {8'h03, 8'h04} |-> !TX_DATA[0] && TX_DATA inside {[2:16]})
    else $error("Bad byte count for a register read.");
  resp_len_a: assert property (TX_VALID && TX_LAST &&
    fc_q inside {[8'h01:8'h04]} |-> idx_q == cnt_q + 8'h02)
    else $error("Response length differs from its byte count.");
  coil_one_a: assert property (COILS != $past(COILS) |->
    $countones(COILS ^ $past(COILS)) == 1)
    else $error("More than one coil changed at once.");
  coil_pulse_a: assert property (COIL_WRITE |=> !COIL_WRITE)
    else $error("Coil write pulse longer than one cycle.");
  cover property (TX_VALID && TX_READY && TX_LAST && fc_q[7]);
  cover property (TX_VALID && TX_READY && TX_LAST && fc_q == 8'h03);
  cover property (COIL_WRITE);
  cover property (TX_VALID && TX_READY && TX_LAST && fc_q == 8'h01);
endmodule : mbrfr_monitor

bind mbrfr_responder mbrfr_monitor i_mon (.CORE_CLK, .RESET_N, .RX_END,
  .STATION_NUMBER, .TX_VALID, .TX_DATA, .TX_LAST, .TX_READY, .COILS,
  .COIL_WRITE);

// ### verification/mbrfr_master_model.sv
// Purpose: Response sink of the remote master.
// Assumes: Stall requests change just after the clock edge.
// Notes:   Accepts a byte only while not stalled.
// ********************************************************************
// Master model
// ********************************************************************
module mbrfr_master_model (
  // Stall request
  input  wire logic stall,
  // Response handshake
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // A slow master withholds ready at random.
  assign tx_ready = ~stall;
endmodule : mbrfr_master_model

// ### verification/tb.sv
// Purpose: Self-checking bench of the read function responder.
// Assumes: Requests of six bytes, one response at a time.
// Notes:   Expected bytes queue up; a watcher compares them.
// ********************************************************************
// Bench
// ********************************************************************
`include "mbrfr_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] STN = 8'h11;
  logic        clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, rx_end = 1'b0;
  logic [7:0]  rx_data = 8'h00, din = 8'h00, coil_m = 8'h00, coils, tx_data;
  logic        tx_valid, tx_last, tx_ready, coil_write, stall = 1'b0;
  logic [15:0] hold [8];
  logic [15:0] inr [8];
  logic [8:0]  q [$];
  logic [31:0] rs = 32'h8f3f;
  int          err_count = 0, total_checks = 0;
  int          wr_count = 0;
  always #50 clk = ~clk;
  mbrfr_responder i_dut (.CORE_CLK(clk), .RESET_N(rst_n),
    .STATION_NUMBER(STN), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_END(rx_end), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_READY(tx_ready), .BINARY_INPUT_CHANNEL(din),
    .ANALOG_INPUT_VALUE({inr[3], inr[2], inr[1], inr[0]}),
    .COUNTER_VALUE(inr[4]),
    .ANALOG_OUTPUT_VALUE({hold[3], hold[2], hold[1], hold[0]}),
    .COUNTER_PRESET(hold[4]), .WATCHDOG_TIMEOUT(hold[5]),
    .MODULE_NAME(hold[6]), .CONN_TIMEOUT(hold[7]), .COILS(coils),
    .COIL_WRITE(coil_write));
  mbrfr_master_model i_master (.stall(stall), .tx_ready(tx_ready));
  function automatic logic [31:0] nx();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : nx
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic put(input logic [7:0] b, input logic l);
    q.push_back({l, b});
  endtask : put
  task automatic step();
    @(posedge clk);
    #1;
    stall = 1'(nx());
  endtask : step
  task automatic rq(input logic [7:0] st, input logic [7:0] fc,
                    input logic [15:0] a, input logic [15:0] n);
    logic [7:0]  ex;
    logic [7:0]  b;
    logic [15:0] w;
    logic [47:0] f;
    ex = 8'h00;
    f = {st, fc, a, n};
    if (fc == `MBRFR_FC_WRITE_COIL)
      ex = a > 16'h7 ? `MBRFR_EXC_ILL_ADDR : (n != `MBRFR_COIL_ON &&
           n != `MBRFR_COIL_OFF) ? `MBRFR_EXC_ILL_VALUE : 8'h00;
    else if (fc == 8'h00 || fc > 8'h04) ex = `MBRFR_EXC_ILL_FUNC;
    else if (n == 16'h0 || n > 16'h8) ex = `MBRFR_EXC_ILL_VALUE;
    else if (a + n > 16'h8) ex = `MBRFR_EXC_ILL_ADDR;
    if (st == STN) begin
      put(st, 1'b0);
      if (ex != 8'h00) begin
        put(fc | `MBRFR_FC_ERR_BIT, 1'b0);
        put(ex, 1'b1);
      end else if (fc == `MBRFR_FC_WRITE_COIL) begin
        for (int i = 4; i >= 0; i--) put(f[i*8 +: 8], i == 0);
        coil_m[a[2:0]] = n[15];
      end else if (fc < 8'h03) begin
        put(fc, 1'b0);
        put(8'h01, 1'b0);
        b = fc == 8'h01 ? coil_m : din;
        put((b >> a[2:0]) & 8'((9'h1 << n[3:0]) - 9'h1), 1'b1);
      end else begin
        put(fc, 1'b0);
        put(8'(n << 1), 1'b0);
        for (int i = 0; i < int'(n); i++) begin
          w = fc == 8'h03 ? hold[a[2:0] + i] : inr[a[2:0] + i];
          put(w[15:8], 1'b0);
          put(w[7:0], i == int'(n) - 1);
        end
      end
    end
    for (int i = 5; i >= 0; i--) begin
      rx_valid = 1'b1;
      rx_data = f[i*8 +: 8];
      step();
    end
    rx_valid = 1'b0;
    rx_end = 1'b1;
    step();
    rx_end = 1'b0;
    for (int i = 0; i < 300 && q.size() > 0; i++) step();
    if (q.size() > 0) begin
      err_count++;
      stop_test();
    end
    repeat (4) step();
  endtask : rq
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (q.size() == 0) begin
        err_count++;
        $display("Error at %0t: seen %h expected none", $time, tx_data);
      end else check({tx_last, tx_data}, q.pop_front());
    end
  end
  always @(posedge clk) begin
    if (coil_write === 1'b1) wr_count++;
  end
  initial begin
    logic [15:0] ra;
    for (int i = 0; i < 8; i++) begin
      hold[i] = 16'(nx());
      inr[i] = 16'(nx());
    end
    inr[5] = `MBRFR_NUM_DI;
    inr[6] = `MBRFR_NUM_DO;
    inr[7] = 16'h0;
    din = 8'(nx());
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rq(STN, 8'h03, 16'h0, 16'h8);
    rq(STN, 8'h04, 16'h0, 16'h8);
    rq(STN, 8'h05, 16'h2, 16'hff00);
    rq(STN, 8'h05, 16'h7, 16'hff00);
    rq(STN, 8'h05, 16'h2, 16'h0);
    check({1'b0, coils}, {1'b0, coil_m});
    check(9'(wr_count), 9'h003);
    rq(STN, 8'h01, 16'h0, 16'h8);
    rq(STN, 8'h02, 16'h3, 16'h5);
    rq(STN, 8'h03, 16'h0, 16'h0);
    rq(STN, 8'h04, 16'h0, 16'h9);
    rq(STN, 8'h03, 16'h7, 16'h2);
    rq(STN, 8'h03, 16'h100, 16'h1);
    rq(STN, 8'h07, 16'h0, 16'h1);
    rq(STN, 8'h05, 16'h8, 16'hff00);
    rq(STN, 8'h05, 16'h1, 16'h1234);
    check(9'(wr_count), 9'h003);
    check({1'b0, coils}, {1'b0, coil_m});
    rq(8'h00, 8'h03, 16'h0, 16'h1);
    rq(8'hf7, 8'h03, 16'h0, 16'h1);
    for (int k = 0; k < 40; k++) begin
      ra = 16'(nx() % 8);
      rq(STN, 8'(1 + nx() % 4), ra, 16'(1 + nx() % (8 - ra)));
    end
    stop_test();
  end
endmodule : tb
